// ---- fss_sequencer_top.sv ----
// switching-state sequencer for a four-switch buck-boost power stage
// Notes on behaviour
// RULE1 - state I: input high, output low on
// RULE2 - state II: input high, output high on
// RULE3 - state III: input low, output high on
// RULE4 - boost starts in I, II after sampling
// RULE5 - boost state I capped by minimum on time
// RULE6 - buck starts in II, III on peak
// RULE7 - buck clock edge returns III to II
// RULE8 - stay buck while off time meets minimum
// RULE9 - too short on/off times select buck-boost
// RULE10 - buck-boost cycle holds states I, II, III
// RULE11 - buck-boost peak check at end of I
// RULE12 - after power-on, initialise then watch enable
// RULE13 - low input supply blocks all switching
// RULE14 - output faults drive open-drain fault low
// RULE15 - mode selection changes applied while running
// RULE16 - same cycle period in every mode
// RULE17 - full state II cycles allowed, no forcing
// RULE18 - hiccup stops switching after peak-limit events
// RULE19 - break before make inside each half bridge
`timescale 1ns/1ps
module fss_sequencer_top
  import fss_pkg::*;
#(
  parameter int CNT_W      = 8,
  parameter int PERIOD     = fss_pkg::SW_PERIOD_CYC,
  parameter int MIN_ON     = fss_pkg::MIN_ON_CYC,
  parameter int MIN_OFF    = fss_pkg::MIN_OFF_CYC,
  parameter int INIT       = fss_pkg::INIT_CYC,
  parameter int HICCUP_OFF = fss_pkg::HICCUP_OFF_CYC,
  parameter int TRIP       = fss_pkg::HICCUP_TRIP,
  parameter int DEAD       = fss_pkg::DEAD_CYC
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // supervision pins
  input  wire logic             por_ok_in,
  input  wire logic             enable_undervoltage_in,
  input  wire logic             input_supply_pin_ok,
  // mode selection and loop demand
  input  wire logic [1:0]       mode_sel_in,
  input  wire logic             vin_above_vout_in,
  input  wire logic [CNT_W-1:0] buck_on_demand,
  input  wire logic [CNT_W-1:0] boost_on_demand,
  // current sense and protection pins
  input  wire logic             current_sampled_in,
  input  wire logic             peak_current_in,
  input  wire logic             peak_limit_in,
  input  wire logic             hiccup_enable_in,
  input  wire logic             output_overvoltage_in,
  // gate commands
  output logic                  input_high_switch,
  output logic                  input_low_switch,
  output logic                  output_high_switch,
  output logic                  output_low_switch,
  // status
  output fss_pkg::fss_mode_e    conv_mode,
  output fss_pkg::fss_state_e   switch_state,
  // open-drain fault pin
  input  wire logic             fault_out_n_in,
  output logic                  fault_out_n_o,
  output logic                  fault_out_n_oe
);

  localparam int OFF_W = 16;

  localparam logic [CNT_W-1:0] PERIOD_V    = CNT_W'(PERIOD);
  localparam logic [CNT_W-1:0] LAST_V      = CNT_W'(PERIOD - 1);
  localparam logic [CNT_W-1:0] MIN_ON_V    = CNT_W'(MIN_ON);
  localparam logic [CNT_W-1:0] MIN_OFF_V   = CNT_W'(MIN_OFF);
  localparam logic [CNT_W-1:0] BOOST_END_V = CNT_W'(PERIOD - MIN_ON - 1);
  localparam logic [CNT_W-1:0] BB_END_V    = CNT_W'(MIN_ON - 1);
  localparam logic [CNT_W-1:0] INIT_V      = CNT_W'(INIT);
  localparam logic [OFF_W-1:0] HIC_OFF_V   = OFF_W'(HICCUP_OFF);
  localparam logic [3:0]       TRIP_V      = 4'(TRIP);

  // parameter sanity
  generate
    if (PERIOD < 2 * MIN_ON + MIN_OFF + 2 || PERIOD >= (1 << CNT_W))
    begin : g_bad_period
      $error("switching period does not fit the counters or minimum times");
    end
    if (INIT < 1 || INIT >= (1 << CNT_W))
    begin : g_bad_init
      $error("initialisation count out of range");
    end
    if (HICCUP_OFF < 1 || HICCUP_OFF >= (1 << OFF_W))
    begin : g_bad_hiccup
      $error("hiccup off count out of range");
    end
    if (TRIP < 1 || TRIP > 15)
    begin : g_bad_trip
      $error("hiccup trip count out of range");
    end
  endgenerate

  // pick the conduction mode for the coming cycle
  function automatic fss_mode_e pick_mode(input logic [1:0]       sel,
                                          input logic             vab,
                                          input logic [CNT_W-1:0] buck_on,
                                          input logic [CNT_W-1:0] boost_on);
    fss_mode_e m;
    m = MODE_BB;
    unique case (sel)
      MSEL_BUCK:  m = MODE_BUCK;
      MSEL_BOOST: m = MODE_BOOST;
      MSEL_BB:    m = MODE_BB;
      MSEL_AUTO:
      begin
        if (vab)
        begin
          // full duty is a plain buck cycle with no forced off time
          if (buck_on >= PERIOD_V)
            m = MODE_BUCK;                                       // [RULE17]
          else if ((PERIOD_V - buck_on) < MIN_OFF_V)
            m = MODE_BB;                                         // [RULE9]
          else
            m = MODE_BUCK;                                       // [RULE8]
        end
        else
        begin
          // zero boost demand is a full state II cycle
          if (boost_on == '0)
            m = MODE_BOOST;                                      // [RULE17]
          else if (boost_on < MIN_ON_V)
            m = MODE_BB;                                         // [RULE9]
          else
            m = MODE_BOOST;
        end
      end
    endcase
    return m;
  endfunction

  // two-flop synchronisers for the supervision, mode selection, sense and protection pins
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] sync_raw;

  assign sync_raw = {mode_sel_in, vin_above_vout_in, output_overvoltage_in,
                     hiccup_enable_in, peak_limit_in, peak_current_in,
                     current_sampled_in, input_supply_pin_ok,
                     enable_undervoltage_in, por_ok_in};

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      sync_meta <= '0;
      sync_q    <= '0;
    end
    else
    begin
      sync_meta <= sync_raw;
      sync_q    <= sync_meta;
    end
  end

  logic       por_s;
  logic       en_s;
  logic       supply_s;
  logic       sampled_s;
  logic       peak_s;
  logic       limit_s;
  logic       hicen_s;
  logic       ovp_s;
  logic       vab_s;
  logic [1:0] msel_s;

  assign por_s     = sync_q[SYB_POR];
  assign en_s      = sync_q[SYB_EN];
  assign supply_s  = sync_q[SYB_SUPPLY];
  assign sampled_s = sync_q[SYB_SAMPLED];
  assign peak_s    = sync_q[SYB_PEAK];
  assign limit_s   = sync_q[SYB_LIMIT];
  assign hicen_s   = sync_q[SYB_HICEN];
  assign ovp_s     = sync_q[SYB_OVP];
  assign vab_s     = sync_q[SYB_VAB];
  assign msel_s    = sync_q[SYB_MSEL +: 2];

  // sample event is the rising edge of the synchronised strobe
  logic sampled_d;
  logic sampled_evt;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      sampled_d <= 1'b0;
    else
      sampled_d <= sampled_s;
  end

  assign sampled_evt = sampled_s && !sampled_d;

  // initialisation wait after power-on; restarts if power-on drops
  logic [CNT_W-1:0] init_cnt;
  logic             ready;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n || !por_s)
    begin
      init_cnt <= '0;
      ready    <= 1'b0;
    end
    else if (init_cnt != INIT_V)
    begin
      init_cnt <= init_cnt + 1'b1;                               // [RULE12]
    end
    else
    begin
      ready <= 1'b1;                                             // [RULE12]
    end
  end

  // switching is allowed only with enable, good supply and no hiccup pause
  logic hiccup_off;
  logic run;

  assign run = ready && en_s && supply_s && !hiccup_off;          // [RULE12] [RULE13]

  // fixed period divider, identical in all modes
  logic [CNT_W-1:0] per_cnt;
  logic             cycle_start;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n || !run)
      per_cnt <= '0;
    else if (per_cnt == LAST_V)
      per_cnt <= '0;                                             // [RULE16]
    else
      per_cnt <= per_cnt + 1'b1;
  end

  assign cycle_start = run && (per_cnt == '0);

  // conduction state machine; the clock edge beats any pending event
  fss_state_e state;
  fss_mode_e  mode;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      mode  <= MODE_BOOST;
    end
    else if (!run)
    begin
      state <= ST_IDLE;                                          // [RULE13]
    end
    else if (cycle_start)
    begin
      // a new selection takes effect at the cycle edge without a stop
      mode <= pick_mode(msel_s, vab_s, buck_on_demand, boost_on_demand); // [RULE15]
      unique case (pick_mode(msel_s, vab_s, buck_on_demand, boost_on_demand))
        MODE_BOOST: state <= (boost_on_demand == '0) ? ST_TWO : ST_ONE; // [RULE4] [RULE17]
        MODE_BUCK:  state <= ST_TWO;                             // [RULE6] [RULE7]
        MODE_BB:    state <= ST_ONE;                             // [RULE10]
      endcase
    end
    else
    begin
      unique case (state)
        ST_IDLE:  state <= ST_IDLE;
        ST_ONE:
        begin
          if (mode == MODE_BB)
          begin
            // peak compare happens once, at the end of the state I slot
            if (per_cnt >= BB_END_V)
              state <= (peak_s || limit_s) ? ST_THREE : ST_TWO;  // [RULE11] [RULE10]
          end
          else if (sampled_evt || limit_s || per_cnt >= BOOST_END_V)
          begin
            state <= ST_TWO;                                     // [RULE4] [RULE5]
          end
        end
        ST_TWO:
        begin
          // boost keeps state II to the cycle end; buck waits for peak
          if (mode != MODE_BOOST && (peak_s || limit_s))
            state <= ST_THREE;                                   // [RULE6] [RULE10]
        end
        ST_THREE: state <= ST_THREE;                             // [RULE7]
      endcase
    end
  end

  // hiccup: count cycles that hit the peak limit, then pause
  logic             limit_seen;
  logic [3:0]       hit_cnt;
  logic [OFF_W-1:0] off_cnt;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      limit_seen <= 1'b0;
    else
      limit_seen <= (cycle_start ? 1'b0 : limit_seen) | (run && limit_s); // set wins
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      hit_cnt    <= '0;
      hiccup_off <= 1'b0;
      off_cnt    <= '0;
    end
    else if (hiccup_off)
    begin
      hit_cnt <= '0;
      if (off_cnt == '0)
        hiccup_off <= 1'b0;
      else
        off_cnt <= off_cnt - 1'b1;                               // [RULE18]
    end
    else if (cycle_start)
    begin
      if (!limit_seen || !hicen_s)
        hit_cnt <= '0;
      else if (hit_cnt + 1'b1 >= TRIP_V)
      begin
        hiccup_off <= 1'b1;                                      // [RULE18]
        off_cnt    <= HIC_OFF_V;
        hit_cnt    <= '0;
      end
      else
        hit_cnt <= hit_cnt + 1'b1;                               // [RULE18]
    end
  end

  // half-bridge requests from the conduction state
  fss_leg_if leg_bus [2] ();

  logic drive_en;
  logic in_want_high;
  logic out_want_high;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      drive_en      <= 1'b0;
      in_want_high  <= 1'b0;
      out_want_high <= 1'b0;
    end
    else
    begin
      drive_en      <= run && (state != ST_IDLE);                // [RULE13]
      // I: in high/out low, II: in high/out high, III: in low/out high
      in_want_high  <= (state == ST_ONE) || (state == ST_TWO);   // [RULE1] [RULE2] [RULE3]
      out_want_high <= (state == ST_TWO) || (state == ST_THREE); // [RULE1] [RULE2] [RULE3]
    end
  end

  assign leg_bus[0].drive_en  = drive_en;
  assign leg_bus[0].want_high = in_want_high;
  assign leg_bus[1].drive_en  = drive_en;
  assign leg_bus[1].want_high = out_want_high;

  // one dead-time stage per half bridge
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_leg
      fss_half_bridge #(
        .DEAD (DEAD)
      ) u_leg (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .bus      (leg_bus[g].leg)
      );
    end
  endgenerate

  // gate outputs come straight from the leg flip-flops
  assign input_high_switch  = leg_bus[0].gate_high;
  assign input_low_switch   = leg_bus[0].gate_low;
  assign output_high_switch = leg_bus[1].gate_high;
  assign output_low_switch  = leg_bus[1].gate_low;

  // status and fault pin; the pin only ever pulls low
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      conv_mode      <= MODE_BOOST;
      switch_state   <= ST_IDLE;
      fault_out_n_o  <= 1'b0;
      fault_out_n_oe <= 1'b0;
    end
    else
    begin
      conv_mode      <= mode;
      switch_state   <= state;
      fault_out_n_o  <= 1'b0;
      fault_out_n_oe <= ovp_s || hiccup_off;                     // [RULE14]
    end
  end

endmodule // fss_sequencer_top

// ---- fss_pkg.sv ----
// shared constants and types for the four-switch state sequencer
package fss_pkg;

  // core clock
  localparam int CLK_PERIOD_NS  = 50;

  // switching period, fixed in every mode
  localparam int SW_PERIOD_NS   = 2500;
  localparam int SW_PERIOD_CYC  = SW_PERIOD_NS / CLK_PERIOD_NS;

  // least times round up, never below one cycle
  localparam int MIN_ON_NS      = 100;
  localparam int MIN_ON_RAW     = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_ON_CYC     = (MIN_ON_RAW < 1) ? 1 : MIN_ON_RAW;
  localparam int MIN_OFF_NS     = 150;
  localparam int MIN_OFF_RAW    = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_OFF_CYC    = (MIN_OFF_RAW < 1) ? 1 : MIN_OFF_RAW;
  localparam int DEAD_TIME_NS   = 44;
  localparam int DEAD_RAW       = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CYC       = (DEAD_RAW < 1) ? 1 : DEAD_RAW;
  localparam int INIT_NS        = 2000;
  localparam int INIT_RAW       = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC       = (INIT_RAW < 1) ? 1 : INIT_RAW;

  // hiccup protection
  localparam int HICCUP_OFF_NS  = 1000000;
  localparam int HICCUP_OFF_CYC = (HICCUP_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HICCUP_TRIP    = 8;

  // mode selection pin codes
  localparam logic [1:0] MSEL_AUTO  = 2'h0;
  localparam logic [1:0] MSEL_BUCK  = 2'h1;
  localparam logic [1:0] MSEL_BOOST = 2'h2;
  localparam logic [1:0] MSEL_BB    = 2'h3;

  // bit positions in the synchroniser vector
  localparam int SYB_POR     = 0;
  localparam int SYB_EN      = 1;
  localparam int SYB_SUPPLY  = 2;
  localparam int SYB_SAMPLED = 3;
  localparam int SYB_PEAK    = 4;
  localparam int SYB_LIMIT   = 5;
  localparam int SYB_HICEN   = 6;
  localparam int SYB_OVP     = 7;
  localparam int SYB_VAB     = 8;
  localparam int SYB_MSEL    = 9;
  localparam int SYNC_W      = 11;

  typedef enum logic [1:0] {MODE_BOOST, MODE_BUCK, MODE_BB} fss_mode_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ONE, ST_TWO, ST_THREE} fss_state_e;

endpackage

// ---- fss_leg_if.sv ----
// request and gate bundle for one half bridge
`timescale 1ns/1ps
interface fss_leg_if;
  logic drive_en;
  logic want_high;
  logic gate_high;
  logic gate_low;

  modport ctrl (output drive_en, output want_high, input gate_high, input gate_low);
  modport leg  (input drive_en, input want_high, output gate_high, output gate_low);
endinterface

// ---- fss_half_bridge.sv ----
// one half bridge with break-before-make dead interval
`timescale 1ns/1ps
module fss_half_bridge
  import fss_pkg::*;
#(
  parameter int DEAD = fss_pkg::DEAD_CYC
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // sequencer side
  fss_leg_if.leg    bus
);

  localparam int DW = 8;
  localparam logic [DW-1:0] DEAD_V = DW'(DEAD);

  generate
    if (DEAD < 1 || DEAD > 255)
    begin : g_bad_dead
      $error("dead interval out of range");
    end
  endgenerate

  logic [DW-1:0] dead_cnt;

  // opposite switch goes off first, then a dead wait, then the wanted one
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      bus.gate_high <= 1'b0;
      bus.gate_low  <= 1'b0;
      dead_cnt      <= DEAD_V;
    end
    else if (!bus.drive_en)
    begin
      bus.gate_high <= 1'b0;
      bus.gate_low  <= 1'b0;
      dead_cnt      <= DEAD_V;
    end
    else if (bus.want_high ? bus.gate_low : bus.gate_high)
    begin
      bus.gate_high <= 1'b0;                           // [RULE19]
      bus.gate_low  <= 1'b0;                           // [RULE19]
      dead_cnt      <= DEAD_V;
    end
    else if (dead_cnt != '0)
    begin
      dead_cnt <= dead_cnt - 1'b1;                     // [RULE19]
    end
    else
    begin
      bus.gate_high <= bus.want_high;
      bus.gate_low  <= !bus.want_high;
    end
  end

endmodule // fss_half_bridge

// ---- fss_seq_props.sv ----
// port-level checker for the four-switch state sequencer
`timescale 1ns/1ps
module fss_seq_props
  import fss_pkg::*;
#(
  parameter int PERIOD = 50,
  parameter int MIN_ON = 2
)
(
  // clock and reset
  input wire logic           core_clk,
  input wire logic           reset_n,
  // watched pins
  input wire logic           output_overvoltage_in,
  input wire logic           input_high_switch,
  input wire logic           input_low_switch,
  input wire logic           output_high_switch,
  input wire logic           output_low_switch,
  input fss_pkg::fss_mode_e  conv_mode,
  input fss_pkg::fss_state_e switch_state,
  input wire logic           fault_out_n_o,
  input wire logic           fault_out_n_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] gates;
  logic [7:0] one_run;
  // gate image in leg order: in high, in low, out high, out low
  assign gates = {input_high_switch, input_low_switch, output_high_switch, output_low_switch};
  // run length of state I, a stuck state I shows as a long run
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || switch_state != ST_ONE)
      one_run <= 8'h00;
    else
      one_run <= one_run + 8'h01;
  end
  in_leg_excl_a: assert property (!(input_high_switch && input_low_switch))
    else $error("input leg shoot-through");
  out_leg_excl_a: assert property (!(output_high_switch && output_low_switch))
    else $error("output leg shoot-through");
  state_one_gates_a: assert property (switch_state == ST_ONE [*5] |-> gates == 4'h9)
    else $error("state I gate pattern wrong");
  state_two_gates_a: assert property (switch_state == ST_TWO [*5] |-> gates == 4'hA)
    else $error("state II gate pattern wrong");
  state_three_gates_a: assert property (switch_state == ST_THREE [*5] |-> gates == 4'h6)
    else $error("state III gate pattern wrong");
  idle_gates_off_a: assert property (switch_state == ST_IDLE [*4] |-> gates == 4'h0)
    else $error("gates on while idle");
  boost_order_a: assert property (switch_state == ST_ONE ##1 switch_state != ST_ONE
    && conv_mode == MODE_BOOST |-> switch_state inside {ST_TWO, ST_IDLE})
    else $error("boost left state I wrongly");
  buck_return_a: assert property (switch_state == ST_THREE ##1 switch_state != ST_THREE
    && conv_mode == MODE_BUCK |-> switch_state inside {ST_TWO, ST_IDLE})
    else $error("buck left state III wrongly");
  buck_no_one_a: assert property (conv_mode == MODE_BUCK |-> switch_state != ST_ONE)
    else $error("state I seen in buck");
  boost_cap_a: assert property (one_run <= PERIOD - MIN_ON)
    else $error("state I longer than cap");
  bb_short_one_a: assert property (conv_mode == MODE_BB |-> one_run <= MIN_ON)
    else $error("buck-boost state I too long");
  fault_ovp_a: assert property (output_overvoltage_in [*5] |-> fault_out_n_oe)
    else $error("overvoltage not flagged");
  fault_level_a: assert property (fault_out_n_oe |-> !fault_out_n_o)
    else $error("fault pin driven high");
  // main scenarios reached
  cover property (switch_state == ST_ONE ##1 switch_state == ST_TWO);
  cover property (conv_mode == MODE_BUCK && switch_state == ST_THREE);
  cover property (conv_mode == MODE_BB && switch_state == ST_THREE);
  cover property ($rose(fault_out_n_oe));
endmodule // fss_seq_props

// ---- fss_stage_model.sv ----
// behavioural full-bridge power stage returning current events
`timescale 1ns/1ps
module fss_stage_model
(
  // clock
  input wire logic       core_clk,
  // gate commands seen
  input wire logic       input_high_switch,
  input wire logic       output_high_switch,
  input wire logic       output_low_switch,
  // response control, delay in cycles
  input wire logic       events_on,
  input wire logic [3:0] rise_dly,
  // current events
  output logic           current_sampled_in,
  output logic           peak_current_in
);
  logic [3:0] mag_cnt;
  logic [3:0] pass_cnt;
  // current builds only while a conducting path stays closed
  always @(posedge core_clk)
  begin
    mag_cnt <= (input_high_switch && output_low_switch) ? mag_cnt + 4'h1 : 4'h0;
    pass_cnt <= (input_high_switch && output_high_switch) ? pass_cnt + 4'h1 : 4'h0;
  end
  // sample is a one-cycle strobe; peak stays up until the path opens or the 4-bit count wraps
  assign current_sampled_in = events_on && mag_cnt == rise_dly;
  assign peak_current_in = events_on && pass_cnt >= rise_dly;
endmodule // fss_stage_model

// ---- fss_sequencer_top_tb.sv ----
// self-checking bench for the four-switch state sequencer
`timescale 1ns/1ps
module fss_sequencer_top_tb;
  import fss_pkg::*;
  localparam int PER = 20;
  localparam logic [5:0] VAB_T = 6'h07;
  localparam logic [7:0] BK_T[6] = '{8'h13, 8'h08, 8'h14, 8'h08, 8'h08, 8'h08};
  localparam logic [7:0] BO_T[6] = '{8'h05, 8'h05, 8'h05, 8'h01, 8'h06, 8'h00};
  localparam fss_mode_e MD_T[6] = '{MODE_BB, MODE_BUCK, MODE_BUCK, MODE_BB, MODE_BOOST,
                                    MODE_BOOST};
  logic       core_clk = 1'b0;
  logic       reset_n, por_ok_in, enable_undervoltage_in, input_supply_pin_ok;
  logic       vin_above_vout_in, current_sampled_in, peak_current_in, peak_limit_in;
  logic       hiccup_enable_in, output_overvoltage_in, fault_out_n_in, events_on, watch;
  logic       input_high_switch, input_low_switch, output_high_switch, output_low_switch;
  logic       fault_out_n_o, fault_out_n_oe;
  logic [1:0] mode_sel_in, prev;
  logic [3:0] rise_dly;
  logic [7:0] buck_on_demand, boost_on_demand;
  fss_mode_e  conv_mode;
  fss_state_e switch_state;
  fss_state_e exp_q[$];
  int         error_cnt, compares;
  wire [3:0]  gates = {input_high_switch, input_low_switch, output_high_switch, output_low_switch};
  // clock and pulled-up fault pin
  always #25 core_clk = ~core_clk;
  assign fault_out_n_in = fault_out_n_oe ? 1'b0 : 1'b1;
  fss_sequencer_top #(.PERIOD(PER), .INIT(2), .HICCUP_OFF(20), .TRIP(2)) i_dut (.core_clk,
    .reset_n, .por_ok_in, .enable_undervoltage_in, .input_supply_pin_ok, .mode_sel_in,
    .vin_above_vout_in, .buck_on_demand, .boost_on_demand, .current_sampled_in,
    .peak_current_in, .peak_limit_in, .hiccup_enable_in, .output_overvoltage_in,
    .input_high_switch, .input_low_switch, .output_high_switch, .output_low_switch,
    .conv_mode, .switch_state, .fault_out_n_in, .fault_out_n_o, .fault_out_n_oe);
  fss_stage_model i_stage (.core_clk, .input_high_switch, .output_high_switch,
    .output_low_switch, .events_on, .rise_dly, .current_sampled_in, .peak_current_in);
  // each state change takes the oldest expected state off the queue;
  // looked at on the falling edge so the registered state has settled
  always @(negedge core_clk)
  begin
    if (watch && exp_q.size() > 0 && switch_state !== prev)
      check(switch_state, exp_q.pop_front());
    prev <= switch_state;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // stop, pick a mode, restart; stopping first keeps the queue aligned
  task automatic restart(input logic [1:0] m);
    watch = 1'b0;
    enable_undervoltage_in = 1'b0;
    mode_sel_in = m;
    rise_dly = 4'h2 + 4'($urandom % 5);
    exp_q.delete();
    tick(6);
    watch = 1'b1;
    enable_undervoltage_in = 1'b1;
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < 300 && exp_q.size() > 0; k++)
      tick(1);
    if (exp_q.size() > 0)
    begin
      error_cnt++;
      conclude();
    end
  endtask
  // cycles between two entries into the cycle-start state
  task automatic meas(input fss_state_e st);
    int n;
    int k;
    n = -1;
    for (k = 0; k < 100; k++)
    begin
      tick(1);
      if (switch_state === st && prev !== st && n >= 0)
        break;
      if (switch_state === st && prev !== st)
        n = 0;
      n = (n >= 0) ? n + 1 : n;
    end
    check(8'(n), 8'(PER));
  endtask
  initial
  begin
    int i;
    {reset_n, watch, peak_limit_in, hiccup_enable_in, output_overvoltage_in} = '0;
    {por_ok_in, enable_undervoltage_in, input_supply_pin_ok, events_on} = 4'hF;
    {mode_sel_in, vin_above_vout_in, rise_dly} = 7'h04;
    void'($urandom(32'h376B));
    buck_on_demand = 8'($urandom % 16);
    boost_on_demand = 8'h03 + 8'($urandom % 10);
    tick(8);
    reset_n = 1'b1;
    check({gates, 2'(switch_state)}, 8'h00);
    restart(MSEL_BOOST);
    exp_q = '{ST_ONE, ST_TWO, ST_ONE, ST_TWO};
    drain();
    check(conv_mode, MODE_BOOST);
    meas(ST_ONE);
    restart(MSEL_BUCK);
    exp_q = '{ST_TWO, ST_THREE, ST_TWO, ST_THREE};
    drain();
    check(conv_mode, MODE_BUCK);
    meas(ST_TWO);
    restart(MSEL_BB);
    exp_q = '{ST_ONE, ST_TWO, ST_THREE, ST_ONE, ST_TWO, ST_THREE};
    drain();
    meas(ST_ONE);
    // no current events: boost state I ends only by the cap
    events_on = 1'b0;
    restart(MSEL_BOOST);
    exp_q = '{ST_ONE, ST_TWO, ST_ONE};
    drain();
    boost_on_demand = 8'h00;
    for (i = 0; i < 2; i++)
    begin
      restart(i ? MSEL_BUCK : MSEL_BOOST);
      exp_q = '{ST_TWO};
      drain();
      tick(PER + 3);
      check(switch_state, ST_TWO);
    end
    events_on = 1'b1;
    // auto selection changed while running
    mode_sel_in = MSEL_AUTO;
    for (i = 0; i < 6; i++)
    begin
      vin_above_vout_in = VAB_T[i];
      buck_on_demand = BK_T[i];
      boost_on_demand = BO_T[i];
      tick(3 * PER);
      check(conv_mode, MD_T[i]);
    end
    // each supervision pin alone stops switching
    for (i = 0; i < 3; i++)
    begin
      {por_ok_in, enable_undervoltage_in, input_supply_pin_ok} = 3'h7 ^ (3'h1 << i);
      tick(6);
      check({gates, 2'(switch_state)}, 8'h00);
      {por_ok_in, enable_undervoltage_in, input_supply_pin_ok} = 3'h7;
      tick(10);
      check(8'(switch_state != ST_IDLE), 8'h01);
    end
    output_overvoltage_in = 1'b1;
    tick(6);
    check({fault_out_n_oe, fault_out_n_in}, 8'h02);
    output_overvoltage_in = 1'b0;
    tick(6);
    check({fault_out_n_oe, fault_out_n_in}, 8'h01);
    // repeated limit events trip hiccup
    {hiccup_enable_in, peak_limit_in} = 2'h3;
    for (i = 0; i < 80 && fault_out_n_oe !== 1'b1; i++)
      tick(1);
    tick(4);
    check({fault_out_n_oe, gates, 2'(switch_state)}, 8'h40);
    peak_limit_in = 1'b0;
    tick(30);
    check({fault_out_n_oe, 1'(switch_state != ST_IDLE)}, 8'h01);
    conclude();
  end
endmodule // fss_sequencer_top_tb
bind fss_sequencer_top fss_seq_props #(.PERIOD(PERIOD), .MIN_ON(MIN_ON)) u_props (
  .core_clk(core_clk), .reset_n(reset_n), .output_overvoltage_in(output_overvoltage_in),
  .input_high_switch(input_high_switch), .input_low_switch(input_low_switch),
  .output_high_switch(output_high_switch), .output_low_switch(output_low_switch),
  .conv_mode(conv_mode), .switch_state(switch_state), .fault_out_n_o(fault_out_n_o),
  .fault_out_n_oe(fault_out_n_oe));
